// ### src/fbst_pkg.sv
// Purpose: Shared constants and types for the FIFO boundary-scan test port
// Assumes: Both ends run on a 50 MHz system clock; tck is sampled, not a clock
// Notes:   Contract
// Contract
// R1 - Capture tdi on each rising tck edge
// R2 - Scan path through instruction, id or bypass
// R3 - Update tdo on each falling tck edge
// R4 - Drive tdo only in shift states
// R5 - Tms at rising tck steers state machine
// R6 - Low trst resets controller at once
// R7 - No power-up initialisation of the controller
// R8 - Reset by trst or five tms-high cycles
// R9 - Fifo outputs off until tap reset
// R10 - Tie trst to fifo master reset
// R11 - Hold trst low when scan unused; the tester drives trst_n high whenever it is idle
// R12 - Undriven tms, tdi, trst read high; no pull-ups are modelled on the link wires
// R13 - All synchronous to tck; idle tck low; the logic here runs on clk and samples tck
// R14 - Full sixteen-state controller with both paths
package fbst_pkg;

	localparam int IR_WIDTH        = 4;
	localparam int ID_WIDTH        = 32;
	localparam int TMS_RESET_COUNT = 5;
	localparam int TCK_HALF_DIV    = 4;

	// Instruction codes and the instruction capture value
	localparam logic [3:0] INS_IDCODE = 4'h2;
	localparam logic [3:0] INS_BYPASS = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// Identity value, arbitrary
	localparam logic [31:0] ID_VALUE = 32'h1234_5679;

	typedef enum logic [15:0] {
		ST_RESET    = 16'h0001,
		ST_IDLE     = 16'h0002,
		ST_SEL_DR   = 16'h0004,
		ST_CAP_DR   = 16'h0008,
		ST_SHIFT_DR = 16'h0010,
		ST_EXIT1_DR = 16'h0020,
		ST_PAUSE_DR = 16'h0040,
		ST_EXIT2_DR = 16'h0080,
		ST_UPD_DR   = 16'h0100,
		ST_SEL_IR   = 16'h0200,
		ST_CAP_IR   = 16'h0400,
		ST_SHIFT_IR = 16'h0800,
		ST_EXIT1_IR = 16'h1000,
		ST_PAUSE_IR = 16'h2000,
		ST_EXIT2_IR = 16'h4000,
		ST_UPD_IR   = 16'h8000
	} fbst_state_type;

	// Next controller state for a tms level
	function automatic fbst_state_type fbst_next(input fbst_state_type s, input logic tms);
		case (s)
			ST_RESET:    fbst_next = tms ? ST_RESET : ST_IDLE;
			ST_IDLE:     fbst_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR:   fbst_next = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR:   fbst_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: fbst_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: fbst_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: fbst_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: fbst_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR:   fbst_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR:   fbst_next = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR:   fbst_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: fbst_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: fbst_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: fbst_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: fbst_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR:   fbst_next = tms ? ST_SEL_DR : ST_IDLE;
			default:     fbst_next = ST_RESET;
		endcase
	endfunction

endpackage

// ### src/fbst_link_if.sv
// Purpose: Boundary-scan link between tester end and device end
// Assumes: Tester samples tdo_o directly; tdo_oe_n is read only by the bench and checker
// Notes:   Enable signals are active low
`timescale 1ns/100ps
`default_nettype none
interface fbst_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic trst_n;
	logic tdo_o;
	logic tdo_oe_n;

	modport device (input tck, input tms, input tdi, input trst_n, output tdo_o, output tdo_oe_n);
	modport tester (output tck, output tms, output tdi, output trst_n, input tdo_o,
		input tdo_oe_n);
endinterface
`default_nettype wire

// ### src/fbst_sync.sv
// Purpose: Two-flop synchroniser for link pins
// Assumes: Destination is clk
// Notes:   First stage read only by second
`timescale 1ns/100ps
`default_nettype none
module fbst_sync #(
	parameter int         W        = 1,
	parameter logic [0:0] INIT_VAL = 1'b1
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// Refuse an empty bus at elaboration
	if (W < 1) begin : gen_bad_width
		$error("fbst_sync width must be positive");
	end

	// Two register stages
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= {W{INIT_VAL}};
			sync_ff <= {W{INIT_VAL}};
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule
`default_nettype wire

// ### src/fbst_device.sv
// Purpose: Device end of the FIFO test access port
// Assumes: tck slower than clk/4; link pins synchronised here
// Notes:   Controller comes up in an unknown-reset condition, outputs off
`timescale 1ns/100ps
`default_nettype none
module fbst_device (
	input  wire logic   clk,
	input  wire logic   rstn,
	fbst_link_if.device link,
	input  wire logic   fifo_master_reset_n,
	output logic        fifo_out_enable,
	output logic [3:0]  instr,
	output logic        tap_in_reset
);
	logic [2:0] pins;
	logic       tck_s;
	logic       tms_s;
	logic       tdi_s;
	logic       trst_s_n;
	logic       tck_d_ff;
	logic       rise;
	logic       fall;
	logic       treset_n;

	fbst_pkg::fbst_state_type state_ff;
	fbst_pkg::fbst_state_type nxt_state;
	logic                                  was_reset_ff;
	logic                                  nxt_was_reset;
	logic [fbst_pkg::IR_WIDTH-1:0]        ir_sh_ff;
	logic [fbst_pkg::IR_WIDTH-1:0]        nxt_ir_sh;
	logic [fbst_pkg::IR_WIDTH-1:0]        ir_ff;
	logic [fbst_pkg::IR_WIDTH-1:0]        nxt_ir;
	logic [fbst_pkg::ID_WIDTH-1:0]        id_sh_ff;
	logic [fbst_pkg::ID_WIDTH-1:0]        nxt_id_sh;
	logic                                  byp_ff;
	logic                                  nxt_byp;
	logic                                  tdo_ff;
	logic                                  nxt_tdo;
	logic                                  tdo_en_ff;
	logic                                  nxt_tdo_en;
	logic [2:0]                            ones_ff;
	logic [2:0]                            nxt_ones;

	// Pin synchroniser resets high, tck synchroniser resets low; no pull-ups are modelled on the link wires
	fbst_sync #(.W(3), .INIT_VAL(1'b1)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.d    ({link.tms, link.tdi, link.trst_n}), // R12
		.q    (pins)
	);
	fbst_sync #(.W(1), .INIT_VAL(1'b0)) u_sync_tck (
		.clk  (clk),
		.rstn (rstn),
		.d    (link.tck),
		.q    (tck_s)
	);
	assign tms_s    = pins[2];
	assign tdi_s    = pins[1];
	assign trst_s_n = pins[0];

	// Tck edge detection
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) tck_d_ff <= 1'b0;
		else tck_d_ff <= tck_s;
	end
	assign rise = tck_s & ~tck_d_ff; // R13
	assign fall = ~tck_s & tck_d_ff;

	// Controller reset: trst wins over any tck edge
	assign treset_n = trst_s_n & fifo_master_reset_n; // R6 R10

	// Shift states drive tdo; any other state leaves the pin released
	function automatic logic in_shift(input fbst_pkg::fbst_state_type s);
		in_shift = (s == fbst_pkg::ST_SHIFT_DR) || (s == fbst_pkg::ST_SHIFT_IR);
	endfunction

	// Identity register sits on the data path only under its own code
	function automatic logic id_selected(input logic [fbst_pkg::IR_WIDTH-1:0] ir);
		id_selected = (ir == fbst_pkg::INS_IDCODE);
	endfunction

	// Instruction port is four bits wide
	if (fbst_pkg::IR_WIDTH != 4) begin : gen_bad_ir
		$error("fbst_device needs a four-bit instruction");
	end

	// Tms run counter holds at most seven
	if (fbst_pkg::TMS_RESET_COUNT < 1 || fbst_pkg::TMS_RESET_COUNT > 7) begin : gen_bad_count
		$error("fbst_device tms reset count out of range");
	end

	// Identity register needs two bits to shift
	if (fbst_pkg::ID_WIDTH < 2) begin : gen_bad_id
		$error("fbst_device identity register too short");
	end

	// Capture value must fill the identity register
	if ($bits(fbst_pkg::ID_VALUE) != fbst_pkg::ID_WIDTH) begin : gen_bad_value
		$error("fbst_device identity value width mismatch");
	end

	// Controller and scan path next values
	always_comb begin
		nxt_state     = state_ff;
		nxt_was_reset = was_reset_ff;
		nxt_ones      = ones_ff;
		nxt_ir_sh     = ir_sh_ff;
		nxt_ir        = ir_ff;
		nxt_id_sh     = id_sh_ff;
		nxt_byp       = byp_ff;
		if (!treset_n) begin
			nxt_state     = fbst_pkg::ST_RESET; // R6 R8
			nxt_was_reset = 1'b1;
			nxt_ones      = 3'd0;
			nxt_ir        = fbst_pkg::INS_IDCODE;
		end else if (rise) begin
			nxt_state = fbst_pkg::fbst_next(state_ff, tms_s); // R5 R14
			case (state_ff)
				fbst_pkg::ST_RESET: nxt_ir = fbst_pkg::INS_IDCODE;
				fbst_pkg::ST_CAP_IR: nxt_ir_sh = fbst_pkg::IR_CAPTURE;
				fbst_pkg::ST_SHIFT_IR: nxt_ir_sh = {tdi_s, ir_sh_ff[fbst_pkg::IR_WIDTH-1:1]}; // R1
				fbst_pkg::ST_UPD_IR: nxt_ir = ir_sh_ff;
				fbst_pkg::ST_CAP_DR: begin
					nxt_id_sh = fbst_pkg::ID_VALUE;
					nxt_byp   = 1'b0;
				end
				fbst_pkg::ST_SHIFT_DR: begin
					if (id_selected(ir_ff)) // R2
						nxt_id_sh = {tdi_s, id_sh_ff[fbst_pkg::ID_WIDTH-1:1]}; // R1
					else
						nxt_byp = tdi_s; // R1
				end
				default: nxt_byp = byp_ff;
			endcase
			// A run of tms-high rises forces reset from any unknown state
			if (tms_s) begin
				if (ones_ff < 3'(fbst_pkg::TMS_RESET_COUNT))
					nxt_ones = ones_ff + 3'd1;
				if (ones_ff >= 3'(fbst_pkg::TMS_RESET_COUNT - 1)) begin
					nxt_state     = fbst_pkg::ST_RESET; // R8
					nxt_was_reset = 1'b1;
					nxt_ir        = fbst_pkg::INS_IDCODE;
				end
			end else begin
				nxt_ones = 3'd0;
			end
		end
	end

	// Tdo next values: on a seen falling tck, never before reset; trst clears the enable at once
	always_comb begin
		nxt_tdo    = tdo_ff;
		nxt_tdo_en = tdo_en_ff;
		if (!treset_n) begin
			nxt_tdo_en = 1'b0; // R4
		end else if (fall && was_reset_ff) begin
			nxt_tdo_en = in_shift(state_ff); // R3 R4
			if (state_ff == fbst_pkg::ST_SHIFT_IR)
				nxt_tdo = ir_sh_ff[0]; // R2 R3
			else if (id_selected(ir_ff))
				nxt_tdo = id_sh_ff[0]; // R2 R3
			else
				nxt_tdo = byp_ff; // R2 R3
		end
	end

	// Reset bookkeeping; controller state left from power-up as unreset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			was_reset_ff <= 1'b0; // R7
			ones_ff      <= 3'd0;
		end else begin
			was_reset_ff <= nxt_was_reset;
			ones_ff      <= nxt_ones;
		end
	end

	// Tdo pin registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tdo_ff    <= 1'b0;
			tdo_en_ff <= 1'b0;
		end else begin
			tdo_ff    <= nxt_tdo;
			tdo_en_ff <= nxt_tdo_en;
		end
	end

	// Scan registers carry no power-up value
	always_ff @(posedge clk) begin
		state_ff <= nxt_state; // R7
		ir_sh_ff <= nxt_ir_sh;
		ir_ff    <= nxt_ir;
		id_sh_ff <= nxt_id_sh;
		byp_ff   <= nxt_byp;
	end

	// Link pin: enable low while the device drives tdo
	assign link.tdo_o    = tdo_ff;
	assign link.tdo_oe_n = ~tdo_en_ff; // R4

	// Fifo side: outputs stay off until the controller has been reset
	assign fifo_out_enable = was_reset_ff; // R9 R11
	assign instr           = was_reset_ff ? ir_ff : fbst_pkg::INS_IDCODE;
	assign tap_in_reset    = was_reset_ff && (state_ff == fbst_pkg::ST_RESET);
endmodule
`default_nettype wire

// ### src/fbst_tester.sv
// Purpose: Tester end: drives tck, tms, tdi, trst and shifts one scan
// Assumes: One command at a time; tck divided from clk
// Notes:   Tck idles low between commands
`timescale 1ns/100ps
`default_nettype none
module fbst_tester #(
	parameter int LEN_MAX = 32
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	fbst_link_if.tester       link,
	input  wire logic         cmd_valid,
	output logic              cmd_ready,
	input  wire logic [63:0]  cmd_tms,
	input  wire logic [63:0]  cmd_tdi,
	input  wire logic [6:0]   cmd_len,
	input  wire logic         cmd_trst,
	output logic              rsp_valid,
	output logic [63:0]       rsp_tdo
);
	logic       tdo_s;
	logic [2:0] div_ff;
	logic [2:0] nxt_div;
	logic       tck_ff;
	logic       nxt_tck;
	logic       busy_ff;
	logic       nxt_busy;
	logic [6:0] cnt_ff;
	logic [6:0] nxt_cnt;
	logic [63:0] tms_ff;
	logic [63:0] nxt_tms;
	logic [63:0] tdi_ff;
	logic [63:0] nxt_tdi;
	logic [63:0] tdo_ff;
	logic [63:0] nxt_tdo_sh;
	logic       trst_ff;
	logic       nxt_trst;
	logic       done_ff;
	logic       nxt_done;

	// Command buffers are 64 bits deep
	if (LEN_MAX < 1 || LEN_MAX > 64) begin : gen_bad_len
		$error("fbst_tester LEN_MAX out of range");
	end

	fbst_sync #(.W(1), .INIT_VAL(1'b1)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.d    (link.tdo_o),
		.q    (tdo_s)
	);

	// Sequencer: tms/tdi set while tck low, tdo read late in the high phase
	always_comb begin
		nxt_div    = div_ff;
		nxt_tck    = tck_ff;
		nxt_busy   = busy_ff;
		nxt_cnt    = cnt_ff;
		nxt_tms    = tms_ff;
		nxt_tdi    = tdi_ff;
		nxt_tdo_sh = tdo_ff;
		nxt_trst   = trst_ff;
		nxt_done   = 1'b0;
		if (!busy_ff) begin
			nxt_trst = 1'b1;
			if (cmd_valid) begin
				nxt_busy = 1'b1;
				nxt_cnt  = cmd_len;
				nxt_tms  = cmd_tms;
				nxt_tdi  = cmd_tdi;
				nxt_trst = ~cmd_trst; // R8
				nxt_div  = 3'd0;
			end
		end else if (div_ff == 3'(fbst_pkg::TCK_HALF_DIV - 1)) begin
			nxt_div = 3'd0;
			if (!tck_ff) begin
				if (cnt_ff == 7'd0) begin
					nxt_busy = 1'b0;
					nxt_done = 1'b1;
				end else begin
					nxt_tck = 1'b1; // R5
				end
			end else begin
				// Both synchroniser paths have settled by the end of the high phase
				nxt_tdo_sh = {tdo_s, tdo_ff[63:1]}; // R3
				nxt_tck    = 1'b0; // R13
				nxt_tms = {1'b1, tms_ff[63:1]};
				nxt_tdi = {1'b1, tdi_ff[63:1]};
				nxt_cnt = cnt_ff - 7'd1;
			end
		end else begin
			nxt_div = div_ff + 3'd1;
		end
	end

	// Registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_ff  <= 3'd0;
			tck_ff  <= 1'b0;
			busy_ff <= 1'b0;
			cnt_ff  <= 7'd0;
			tms_ff  <= 64'h0000_0000_0000_0000;
			tdi_ff  <= 64'h0000_0000_0000_0000;
			tdo_ff  <= 64'h0000_0000_0000_0000;
			trst_ff <= 1'b1;
			done_ff <= 1'b0;
		end else begin
			div_ff  <= nxt_div;
			tck_ff  <= nxt_tck;
			busy_ff <= nxt_busy;
			cnt_ff  <= nxt_cnt;
			tms_ff  <= nxt_tms;
			tdi_ff  <= nxt_tdi;
			tdo_ff  <= nxt_tdo_sh;
			trst_ff <= nxt_trst;
			done_ff <= nxt_done;
		end
	end

	assign link.tck    = tck_ff;
	assign link.tms    = tms_ff[0];
	assign link.tdi    = tdi_ff[0];
	assign link.trst_n = trst_ff; // R6
	assign cmd_ready   = ~busy_ff;
	assign rsp_valid   = done_ff;
	assign rsp_tdo     = tdo_ff;
endmodule
`default_nettype wire

// ### testbench/fbst_link_sva.sv
// Purpose: Checker for the boundary-scan link between tester and device
// Assumes: Tck is a level made from clk, four clocks per half period
// Notes:   Watches only the interface signals
`timescale 1ns/100ps
`default_nettype none
module fbst_link_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	input wire logic tdo_o,
	input wire logic tdo_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Link timing and pin behaviour
	tck_high_a: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
		else $error("tck high phase not four clocks");
	tck_low_a: assert property ($fell(tck) |-> !tck [*4])
		else $error("tck low phase shorter than four clocks");
	tms_steady_a: assert property ($changed(tms) |-> !tck)
		else $error("tms moved while tck high");
	tdi_steady_a: assert property ($changed(tdi) |-> !tck)
		else $error("tdi moved while tck high");
	trst_steady_a: assert property ($changed(trst_n) |-> !tck)
		else $error("trst moved while tck high");
	reset_idle_a: assert property ($rose(rstn) |-> !tck && trst_n)
		else $error("tester link not idle after reset");
	trst_off_a: assert property (!trst_n |-> ##[0:6] tdo_oe_n)
		else $error("tdo still driven during trst");
	tdo_fall_a: assert property ($changed(tdo_o) && !tdo_oe_n |-> !tck)
		else $error("tdo changed while tck high");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: Self-checking bench joining tester end and device end
// Assumes: Commands go through the tester; device outputs checked after
// Notes:   Device sees link edges a few clocks late, so checks wait
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clk;
	logic        rstn;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [63:0] cmd_tms;
	logic [63:0] cmd_tdi;
	logic [6:0]  cmd_len;
	logic        cmd_trst;
	logic        rsp_valid;
	logic [63:0] rsp_tdo;
	logic        fmr_n;
	logic        out_en;
	logic [3:0]  instr;
	logic        in_reset;
	int          miscompares;
	int          compares;

	fbst_link_if link ();
	fbst_device fbst_device_inst (.clk(clk), .rstn(rstn), .link(link.device),
		.fifo_master_reset_n(fmr_n), .fifo_out_enable(out_en), .instr(instr),
		.tap_in_reset(in_reset));
	fbst_tester #(.LEN_MAX(64)) fbst_tester_inst (.clk(clk), .rstn(rstn), .link(link.tester),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_tms(cmd_tms), .cmd_tdi(cmd_tdi),
		.cmd_len(cmd_len), .cmd_trst(cmd_trst), .rsp_valid(rsp_valid), .rsp_tdo(rsp_tdo));
	fbst_link_sva fbst_link_sva_inst (.clk(clk), .rstn(rstn), .tck(link.tck), .tms(link.tms),
		.tdi(link.tdi), .trst_n(link.trst_n), .tdo_o(link.tdo_o), .tdo_oe_n(link.tdo_oe_n));

	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Verdict and end of run
	task results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Compare one value
	task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One tester command, waits for its answer
	task run(input logic [63:0] tms, input logic [63:0] tdi, input logic [6:0] len,
		input logic trst);
		int i;
		@(negedge clk);
		cmd_tms = tms;
		cmd_tdi = tdi;
		cmd_len = len;
		cmd_trst = trst;
		cmd_valid = 1'b1;
		for (i = 0; i < 50 && !cmd_ready; i++) @(negedge clk);
		if (!cmd_ready) begin
			miscompares++;
			results();
		end
		@(negedge clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 1000 && !rsp_valid; i++) @(negedge clk);
		if (i == 1000 || !rsp_valid) begin
			miscompares++;
			results();
		end
		repeat (8) @(negedge clk);
	endtask

	// Four tms-high cycles are not enough, five are
	task t_tms_reset;
		chk("tdo_oe_n", 64'h1, link.tdo_oe_n);
		run(64'hF, 64'h0, 7'd4, 1'b0);
		chk("out_en", 64'h0, out_en);
		run(64'h1, 64'h0, 7'd1, 1'b0);
		chk("out_en", 64'h1, out_en);
		chk("in_reset", 64'h1, in_reset);
		chk("instr", fbst_pkg::INS_IDCODE, instr);
		$display("test tms_reset done");
	endtask

	// Identity read through the data path
	task t_idcode;
		run(64'h18_0000_0002, 64'h0, 7'd38, 1'b0);
		chk("id", fbst_pkg::ID_VALUE, rsp_tdo[61:30]);
		chk("tdo_oe_n", 64'h1, link.tdo_oe_n);
		$display("test idcode done");
	endtask

	// Instruction load, then one-bit bypass delay
	task t_bypass;
		run(64'h183, 64'hF0, 7'd10, 1'b0);
		chk("ir_capture", fbst_pkg::IR_CAPTURE, rsp_tdo[61:58]);
		chk("instr", fbst_pkg::INS_BYPASS, instr);
		run(64'hC01, 64'h590, 7'd13, 1'b0);
		chk("bypass", 64'h64, rsp_tdo[61:54]);
		$display("test bypass done");
	endtask

	// Trst with tms low still resets the controller
	task t_trst;
		run(64'h0, 64'h0, 7'd2, 1'b1);
		chk("in_reset", 64'h1, in_reset);
		chk("instr", fbst_pkg::INS_IDCODE, instr);
		$display("test trst done");
	endtask

	// Fifo master reset also resets the controller
	task t_master_reset;
		run(64'h0, 64'h0, 7'd1, 1'b0);
		chk("in_reset", 64'h0, in_reset);
		fmr_n = 1'b0;
		repeat (6) @(negedge clk);
		chk("in_reset", 64'h1, in_reset);
		fmr_n = 1'b1;
		$display("test master_reset done");
	endtask

	// Main sequence
	initial begin
		miscompares = 0;
		compares = 0;
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_tms = 64'h0;
		cmd_tdi = 64'h0;
		cmd_len = 7'h0;
		cmd_trst = 1'b0;
		fmr_n = 1'b1;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		t_tms_reset();
		t_idcode();
		t_bypass();
		t_trst();
		t_master_reset();
		results();
	end
endmodule
`default_nettype wire
